// ===== hw/blank_timer.sv
// Loadable down-counter that times one blanking window
`timescale 1ns/100ps
module blank_timer
  import bridge_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic [W-1:0] len,
  // Status
  output logic busy
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt; // Remaining ticks
  } timer_state_t;

  timer_state_t st_reg;
  timer_state_t st_next;

  // Reload on start, count down on ticks
  always_comb begin
    st_next = st_reg;
    if (start) begin
      st_next.cnt = len;
    end else if (tick && (st_reg.cnt != '0)) begin
      st_next.cnt = st_reg.cnt - W'(1);
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Window open while ticks remain
  assign busy = (st_reg.cnt != '0);

endmodule

// ===== hw/bridge_pkg.sv
// Constants, types and carriers shared by the dual bridge control logic
package bridge_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int ANALOG_BLANK_NS = 400;
  localparam int ANALOG_BLANK_CYC = (ANALOG_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ANALOG_BLANK_LEN = 8'(ANALOG_BLANK_CYC);
  localparam logic [7:0] DBLANK_SHORT = 8'h04;
  localparam logic [7:0] DBLANK_LONG = 8'h06;
  localparam logic [3:0] CHOP_LAST = 4'hF;
  localparam logic [3:0] MDT_START = 4'hA;
  localparam logic [15:0] OSC_DIV_RESET = 16'h007D;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] OSC_DIV_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam int CTRL_CHOP_EN_BIT = 0;
  localparam logic CTRL_CHOP_EN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // Control inputs of one channel
  typedef struct packed {
    logic gate;
    logic dir1;
    logic dir2;
  } ctl_in_t;

  // Drive of one bridge; oe low means high impedance
  typedef struct packed {
    logic pos;
    logic neg;
    logic oe;
  } bridge_drv_t;

  // Chopping phase, one-hot
  typedef enum logic [2:0] {
    PH_CHARGE = 3'h1,
    PH_SLOW = 3'h2,
    PH_FAST = 3'h4
  } chop_phase_t;

  // State of the control block, blank timers aside
  typedef struct packed {
    ctl_in_t in_a;
    ctl_in_t in_b;
    logic [15:0] osc_div;
    logic [15:0] osc_cnt;
    logic [3:0] chop_cnt;
    chop_phase_t ph_a;
    chop_phase_t ph_b;
    bridge_drv_t drv_a;
    bridge_drv_t drv_b;
    logic standby;
    logic chop_en;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctrl_state_t;

endpackage

// ===== hw/dual_bridge_ctrl.sv
// Dual bridge input decode, chopping and blanking with an AXI4-Lite register slave
`timescale 1ns/100ps
module dual_bridge_ctrl
  import bridge_pkg::*;
#(
  parameter logic [15:0] OSC_DIV_DEFAULT = OSC_DIV_RESET
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel A control inputs
  input wire logic chan_a_dir_in1,
  input wire logic chan_a_dir_in2,
  input wire logic chan_a_gate_in,
  // Channel B control inputs
  input wire logic chan_b_dir_in1,
  input wire logic chan_b_dir_in2,
  input wire logic chan_b_gate_in,
  // Straps
  input wire logic bridge_pairing_strap,
  input wire logic blank_length_select,
  // Current comparator results, high when current is above the limit
  input wire logic chan_a_over_limit,
  input wire logic chan_b_over_limit,
  // Bridge A outputs
  output logic chan_a_out_pos,
  output logic chan_a_out_pos_oe,
  output logic chan_a_out_neg,
  output logic chan_a_out_neg_oe,
  // Bridge B outputs
  output logic chan_b_out_pos,
  output logic chan_b_out_pos_oe,
  output logic chan_b_out_neg,
  output logic chan_b_out_neg_oe,
  // Standby indication
  output logic standby,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Truth table of one bridge
  function automatic bridge_drv_t decode(input ctl_in_t c);
    bridge_drv_t d;
    d = '0;
    if (c.dir1 && c.dir2) begin
      d = '{pos: 1'b0, neg: 1'b0, oe: 1'b1};
    end else if (!c.gate) begin
      if (c.dir1 || c.dir2) begin
        d = '{pos: 1'b0, neg: 1'b0, oe: 1'b1};
      end else begin
        d = '0;
      end
    end else if (c.dir1) begin
      d = '{pos: 1'b1, neg: 1'b0, oe: 1'b1};
    end else if (c.dir2) begin
      d = '{pos: 1'b0, neg: 1'b1, oe: 1'b1};
    end else begin
      d = '0;
    end
    return d;
  endfunction

  // Apply the chopping phase to a driving bridge
  function automatic bridge_drv_t chop(input bridge_drv_t d, input chop_phase_t ph,
                                       input logic en);
    bridge_drv_t r;
    r = d;
    if (en && d.oe && (d.pos != d.neg)) begin
      unique case (ph)
        PH_CHARGE: r = d;
        PH_SLOW: r = '{pos: 1'b0, neg: 1'b0, oe: 1'b1};
        PH_FAST: r = '{pos: d.neg, neg: d.pos, oe: 1'b1};
        default: r = d;
      endcase
    end
    return r;
  endfunction

  // Step of the mixed decay sequence
  function automatic chop_phase_t step(input chop_phase_t ph, input logic restart,
                                       input logic lim, input logic masked,
                                       input logic [3:0] cnt);
    chop_phase_t n;
    n = ph;
    if (restart) begin
      n = PH_CHARGE;
    end else begin
      unique case (ph)
        PH_CHARGE: begin
          if (lim && !masked) begin
            n = (cnt >= MDT_START) ? PH_FAST : PH_SLOW;
          end
        end
        PH_SLOW: begin
          if (cnt >= MDT_START) begin
            n = PH_FAST;
          end
        end
        PH_FAST: n = PH_FAST;
        default: n = PH_CHARGE;
      endcase
    end
    return n;
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ctrl_state_t st_reg; // Registered state
  ctrl_state_t st_next; // Next state
  ctl_in_t pin_a; // Channel A pins
  ctl_in_t pin_b; // Channel B pins
  logic osc_tick; // Internal oscillator period
  logic chop_wrap; // Last count of a chopping period
  logic dir_change; // A direction pin moved; B pins count only when unpaired
  logic restart_a; // Charge restart, bridge A
  logic restart_b; // Charge restart, bridge B
  logic dstart_a; // Blank start, bridge A
  logic dstart_b; // Blank start, bridge B
  logic dbusy_a; // Digital blanking, A
  logic dbusy_b; // Digital blanking, B
  logic abusy_a; // Analog blanking, A
  logic abusy_b; // Analog blanking, B
  logic masked_a; // Sensing masked, A
  logic masked_b; // Sensing masked, B
  logic [7:0] dlen; // Digital blank length
  logic stby; // Standby condition
  logic [31:0] div_wr; // Divider word after byte-lane merge

  assign pin_a = '{gate: chan_a_gate_in, dir1: chan_a_dir_in1, dir2: chan_a_dir_in2};
  assign pin_b = '{gate: chan_b_gate_in, dir1: chan_b_dir_in1, dir2: chan_b_dir_in2};
  assign div_wr = merge({16'h0000, st_reg.osc_div}, st_reg.wdata, st_reg.wstrb);

  // ----------------------------------------
  // Oscillator and chopping period
  // ----------------------------------------
  assign osc_tick = (st_reg.osc_cnt == '0);
  assign chop_wrap = osc_tick && (st_reg.chop_cnt == CHOP_LAST);

  // ----------------------------------------
  // Blanking triggers and timers
  // ----------------------------------------
  assign dir_change = (pin_a.dir1 != st_reg.in_a.dir1) || (pin_a.dir2 != st_reg.in_a.dir2)
                   || (!bridge_pairing_strap && (pin_b[1:0] != st_reg.in_b[1:0]));
  assign stby = bridge_pairing_strap ? (pin_a == '0)
                                     : ((pin_a == '0) && (pin_b == '0));
  assign restart_a = chop_wrap || dir_change || stby;
  assign restart_b = restart_a;
  assign dstart_a = chop_wrap || dir_change;
  assign dstart_b = dstart_a;
  assign dlen = blank_length_select ? DBLANK_LONG : DBLANK_SHORT;
  assign masked_a = dbusy_a || abusy_a;
  assign masked_b = bridge_pairing_strap ? masked_a : (dbusy_b || abusy_b);

  // Digital blanking on oscillator ticks
  blank_timer #(.W(8)) u_dblank_a (
    .aclk(aclk), .aresetn(aresetn), .tick(osc_tick), .start(dstart_a), .len(dlen),
    .busy(dbusy_a)
  );
  blank_timer #(.W(8)) u_dblank_b (
    .aclk(aclk), .aresetn(aresetn), .tick(osc_tick), .start(dstart_b), .len(dlen),
    .busy(dbusy_b)
  );

  // Analog blanking on every clock
  blank_timer #(.W(8)) u_ablank_a (
    .aclk(aclk), .aresetn(aresetn), .tick(1'b1), .start(dstart_a),
    .len(ANALOG_BLANK_LEN), .busy(abusy_a)
  );
  blank_timer #(.W(8)) u_ablank_b (
    .aclk(aclk), .aresetn(aresetn), .tick(1'b1), .start(dstart_b),
    .len(ANALOG_BLANK_LEN), .busy(abusy_b)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // Sample pins
    st_next.in_a = pin_a;
    st_next.in_b = pin_b;
    // Oscillator divider and period counter
    if (osc_tick) begin
      st_next.osc_cnt = st_reg.osc_div;
      st_next.chop_cnt = st_reg.chop_cnt + 4'h1;
    end else begin
      st_next.osc_cnt = st_reg.osc_cnt - 16'h0001;
    end
    // Chopping phases
    st_next.ph_a = step(st_reg.ph_a, restart_a, chan_a_over_limit ||
                        (bridge_pairing_strap && chan_b_over_limit),
                        masked_a, st_reg.chop_cnt);
    st_next.ph_b = step(st_reg.ph_b, restart_b, chan_b_over_limit, masked_b,
                        st_reg.chop_cnt);
    // Bridge decode; pins take effect at the next clock edge
    st_next.drv_a = chop(decode(pin_a), restart_a ? PH_CHARGE : st_reg.ph_a,
                         st_reg.chop_en);
    if (bridge_pairing_strap) begin
      st_next.ph_b = st_next.ph_a;
      st_next.drv_b = st_next.drv_a;
    end else begin
      st_next.drv_b = chop(decode(pin_b), restart_b ? PH_CHARGE : st_reg.ph_b,
                           st_reg.chop_en);
    end
    st_next.standby = stby;
    // Write address channel
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.waddr = s_axi_awaddr;
      st_next.aw_have = 1'b1;
      st_next.awready = 1'b0;
    end
    // Write data channel
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
      st_next.w_have = 1'b1;
      st_next.wready = 1'b0;
    end
    // Perform a write once both halves are held
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.waddr)
        CTRL_OFFSET: begin
          if (st_reg.wstrb[0]) begin
            st_next.chop_en = st_reg.wdata[CTRL_CHOP_EN_BIT];
          end
        end
        OSC_DIV_OFFSET: st_next.osc_div = div_wr[15:0];
        STATUS_OFFSET: st_next.bresp = RESP_OKAY;
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    // Write response
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    // Read address and data
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFFSET: st_next.rdata = {31'h00000000, st_reg.chop_en};
        OSC_DIV_OFFSET: st_next.rdata = {16'h0000, st_reg.osc_div};
        STATUS_OFFSET: begin
          st_next.rdata = {11'h000, st_reg.chop_cnt, st_reg.drv_b, st_reg.drv_a,
                           st_reg.ph_b, st_reg.ph_a, masked_b, masked_a,
                           blank_length_select, bridge_pairing_strap, st_reg.standby};
        end
        default: begin
          st_next.rdata = 32'h00000000;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.osc_div <= OSC_DIV_DEFAULT;
      st_reg.ph_a <= PH_CHARGE;
      st_reg.ph_b <= PH_CHARGE;
      st_reg.chop_en <= CTRL_CHOP_EN_RESET;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign chan_a_out_pos = st_reg.drv_a.pos;
  assign chan_a_out_pos_oe = st_reg.drv_a.oe;
  assign chan_a_out_neg = st_reg.drv_a.neg;
  assign chan_a_out_neg_oe = st_reg.drv_a.oe;
  assign chan_b_out_pos = st_reg.drv_b.pos;
  assign chan_b_out_pos_oe = st_reg.drv_b.oe;
  assign chan_b_out_neg = st_reg.drv_b.neg;
  assign chan_b_out_neg_oe = st_reg.drv_b.oe;
  assign standby = st_reg.standby;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;

endmodule

// ===== verification/dual_bridge_chk.sv
// Checker of bridge decode, pairing and standby at the control block ports
`timescale 1ns/100ps
module dual_bridge_chk
  import bridge_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control pins and comparators
  input wire logic chan_a_dir_in1, chan_a_dir_in2, chan_a_gate_in,
  input wire logic chan_b_dir_in1, chan_b_dir_in2, chan_b_gate_in,
  input wire logic bridge_pairing_strap, chan_a_over_limit, chan_b_over_limit,
  // Bridge outputs
  input wire logic chan_a_out_pos, chan_a_out_pos_oe, chan_a_out_neg, chan_a_out_neg_oe,
  input wire logic chan_b_out_pos, chan_b_out_pos_oe, chan_b_out_neg, chan_b_out_neg_oe,
  input wire logic standby
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [9:0] quiet_reg; // Cycles since any over-limit, saturating
  logic [2:0] drv_a, drv_b; // {pos, neg, oe}
  logic sb_cond; // Pins ask for standby
  assign drv_a = {chan_a_out_pos, chan_a_out_neg, chan_a_out_pos_oe};
  assign drv_b = {chan_b_out_pos, chan_b_out_neg, chan_b_out_pos_oe};
  assign sb_cond = !chan_a_gate_in && !chan_a_dir_in1 && !chan_a_dir_in2 &&
    (bridge_pairing_strap || (!chan_b_gate_in && !chan_b_dir_in1 && !chan_b_dir_in2));
  // Decay phases may linger after an over-limit, so decode checks wait
  always_ff @(posedge aclk) begin
    if (!aresetn) quiet_reg <= 10'h3FF;
    else if (chan_a_over_limit || chan_b_over_limit) quiet_reg <= 10'h000;
    else if (quiet_reg != 10'h3FF) quiet_reg <= quiet_reg + 10'h001;
  end
  // Decoded drive matches pin levels; value bits only matter when driven
  function automatic logic fits(logic [2:0] got, logic g, logic d1, logic d2);
    logic [2:0] e;
    if (d1 && d2) e = 3'h1;
    else if (!g) e = (d1 || d2) ? 3'h1 : 3'h0;
    else e = {d1, d2, d1 || d2};
    return (got[0] == e[0]) && (!e[0] || got[2:1] == e[2:1]);
  endfunction
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Decode is live: out of reset and no decay pending
  sequence s_live;
    quiet_reg == 10'h3FF && $past(aresetn);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  fwd_rev_a: assert property (
    s_live ##0 $past(chan_a_gate_in && (chan_a_dir_in1 ^ chan_a_dir_in2))
    |-> drv_a == {$past(chan_a_dir_in1), $past(chan_a_dir_in2), 1'b1})
    else $error("bridge A drive polarity wrong");
  short_brake_a: assert property (
    s_live ##0 $past((chan_a_dir_in1 && chan_a_dir_in2) ||
    (!chan_a_gate_in && (chan_a_dir_in1 || chan_a_dir_in2))) |-> drv_a == 3'h1)
    else $error("bridge A not braking");
  stop_hiz_a: assert property (
    s_live ##0 $past(chan_a_gate_in && !chan_a_dir_in1 && !chan_a_dir_in2)
    |-> !chan_a_out_pos_oe && !chan_a_out_neg_oe)
    else $error("bridge A driven in stop");
  idle_hiz_a: assert property (
    s_live ##0 $past(!chan_a_gate_in && !chan_a_dir_in1 && !chan_a_dir_in2)
    |-> !chan_a_out_pos_oe && !chan_a_out_neg_oe)
    else $error("bridge A driven while idle");
  indep_b_a: assert property (
    s_live ##0 !$past(bridge_pairing_strap)
    |-> fits(drv_b, $past(chan_b_gate_in), $past(chan_b_dir_in1), $past(chan_b_dir_in2)))
    else $error("bridge B not following its own pins");
  paired_b_a: assert property (
    s_live ##0 $past(bridge_pairing_strap)
    |-> fits(drv_b, $past(chan_a_gate_in), $past(chan_a_dir_in1), $past(chan_a_dir_in2)))
    else $error("bridge B not following channel A when paired");
  standby_cond_a: assert property (
    $past(aresetn) |-> standby == $past(sb_cond))
    else $error("standby does not match pin levels");
  oe_pair_a: assert property (
    chan_a_out_pos_oe == chan_a_out_neg_oe && chan_b_out_pos_oe == chan_b_out_neg_oe)
    else $error("bridge output enables differ");
  reset_idle_a: assert property (
    $rose(aresetn) |-> !chan_a_out_pos_oe && !chan_b_out_pos_oe && !standby)
    else $error("outputs not idle after reset");
endmodule

bind dual_bridge_ctrl dual_bridge_chk u_dual_bridge_chk (.*);

// ===== verification/dual_bridge_input_decode_blanking_tb.sv
// Self-checking bench for the dual bridge control block
`timescale 1ns/100ps
module dual_bridge_input_decode_blanking_tb
  import bridge_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  ctl_in_t req_a = 3'h0, req_b = 3'h0; // Requests to the controller model
  logic req_strap = 1'b0;
  logic blank_length_select = 1'b0, chan_a_over_limit = 1'b0, chan_b_over_limit = 1'b0;
  logic chan_a_dir_in1, chan_a_dir_in2, chan_a_gate_in, bridge_pairing_strap;
  logic chan_b_dir_in1, chan_b_dir_in2, chan_b_gate_in, standby;
  logic chan_a_out_pos, chan_a_out_pos_oe, chan_a_out_neg, chan_a_out_neg_oe;
  logic chan_b_out_pos, chan_b_out_pos_oe, chan_b_out_neg, chan_b_out_neg_oe;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0;
  int total_checks = 0;
  always #2.5 aclk = ~aclk;
  dual_bridge_ctrl u_dual_bridge_ctrl (.*);
  mcu_model u_mcu_model (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Only the enable counts when high impedance is expected
  task automatic chk_drv(input bridge_drv_t got, input bridge_drv_t exp);
    total_checks++;
    if (exp.oe ? (got !== exp) : (got.oe !== 1'b0)) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic bridge_drv_t exp_drv(input ctl_in_t c);
    if (c.dir1 && c.dir2) return 3'h1;
    if (!c.gate) return {2'h0, c.dir1 || c.dir2};
    return {c.dir1, c.dir2, c.dir1 || c.dir2};
  endfunction
  function automatic bridge_drv_t drv_a();
    return {chan_a_out_pos, chan_a_out_neg, chan_a_out_pos_oe};
  endfunction
  function automatic bridge_drv_t drv_b();
    return {chan_b_out_pos, chan_b_out_neg, chan_b_out_pos_oe};
  endfunction
  // New pin request, then sample once outputs settle
  task automatic put(input ctl_in_t a, input ctl_in_t b, input logic s);
    @(posedge aclk);
    req_a <= a;
    req_b <= b;
    req_strap <= s;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic at, wt, bt;
    bt = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bt) begin
      @(negedge aclk);
      at = s_axi_awready && s_axi_awvalid;
      wt = s_axi_wready && s_axi_wvalid;
      bt = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge aclk);
      if (at === 1'b1) s_axi_awvalid <= 1'b0;
      if (wt === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic at, rt;
    rt = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rt) begin
      @(negedge aclk);
      at = s_axi_arready && s_axi_arvalid;
      rt = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (at === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // Counts cycles until bridge A forward drive equals v
  task automatic wait_fwd(input logic v, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((chan_a_out_pos & ~chan_a_out_neg & chan_a_out_pos_oe) !== v && n < 2000);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    put(3'h0, 3'h0, 1'b0);
    chk_word(32'(standby), 32'h1);
    chk_drv(drv_a(), 3'h0);
    axr(CTRL_OFFSET, d, r);
    chk_word(d, 32'h1);
    axr(OSC_DIV_OFFSET, d, r);
    chk_word(d, 32'(OSC_DIV_RESET));
    $display("t_reset done");
  endtask
  // Every pin code on A, the mirrored code on B
  task automatic t_decode();
    for (int i = 0; i < 8; i++) begin
      put(ctl_in_t'(i[2:0]), ctl_in_t'(3'(7 - i)), 1'b0);
      chk_drv(drv_a(), exp_drv(ctl_in_t'(i[2:0])));
      chk_drv(drv_b(), exp_drv(ctl_in_t'(3'(7 - i))));
      chk_word(32'(standby), 32'h0);
    end
    put(3'h0, 3'h0, 1'b0);
    $display("t_decode done");
  endtask
  // Paired: B pins inverted to prove they are ignored
  task automatic t_paired();
    for (int i = 0; i < 8; i++) begin
      put(ctl_in_t'(i[2:0]), ctl_in_t'(3'(~i)), 1'b1);
      chk_drv(drv_a(), exp_drv(ctl_in_t'(i[2:0])));
      chk_drv(drv_b(), exp_drv(ctl_in_t'(i[2:0])));
      chk_word(32'(standby), 32'(i == 0));
    end
    put(3'h0, 3'h0, 1'b1);
    put(3'h0, 3'h4, 1'b0);
    chk_word(32'(standby), 32'h0);
    $display("t_paired done");
  endtask
  task automatic t_axi();
    logic [31:0] d;
    logic [1:0] r;
    axw(OSC_DIV_OFFSET, 32'h0000001F, r);
    chk_word(32'(r), 32'(RESP_OKAY));
    axr(OSC_DIV_OFFSET, d, r);
    chk_word(d, 32'h1F);
    axw(CTRL_OFFSET, 32'h00000000, r);
    axr(CTRL_OFFSET, d, r);
    chk_word(d, 32'h0);
    axw(CTRL_OFFSET, 32'h00000001, r);
    axw(STATUS_OFFSET, 32'hFFFFFFFF, r);
    chk_word(32'(r), 32'(RESP_OKAY));
    axw(8'h40, 32'hFFFFFFFF, r);
    chk_word(32'(r), 32'(RESP_SLVERR));
    axr(8'h40, d, r);
    chk_word({d[29:0], r}, {30'h0, RESP_SLVERR});
    axr(STATUS_OFFSET, d, r);
    chk_word(32'(d[1]), 32'h0);
    $display("t_axi done");
  endtask
  // Over-limit held: forward only while blanked, once per chopping period;
  // a short divider lets the fixed analog window outlast the digital one
  task automatic t_blank(input logic sel, input logic [15:0] div);
    int c, p, t, lo, hi;
    logic [1:0] r;
    t = int'(div) + 1;
    lo = (sel ? 5 : 3) * t;
    hi = (sel ? 6 : 4) * t + 4;
    if (lo < ANALOG_BLANK_CYC) lo = ANALOG_BLANK_CYC;
    if (hi < ANALOG_BLANK_CYC + 4) hi = ANALOG_BLANK_CYC + 4;
    axw(OSC_DIV_OFFSET, 32'(div), r);
    @(posedge aclk);
    blank_length_select <= sel;
    chan_a_over_limit <= 1'b1;
    put(3'h6, 3'h0, 1'b0);
    wait_fwd(1'b0, c);
    wait_fwd(1'b1, c);
    wait_fwd(1'b0, c);
    wait_fwd(1'b1, p);
    chk_word(32'(c + p), 32'(16 * t));
    chk_word(32'(c >= lo && c <= hi), 32'h1);
    $display("t_blank done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_decode();
    t_paired();
    t_axi();
    t_blank(1'b0, 16'h001F);
    t_blank(1'b1, 16'h001F);
    t_blank(1'b0, 16'h0007);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    conclude();
  end
endmodule

// ===== verification/mcu_model.sv
// Controller model that drives the bridge control pins and the pairing strap
`timescale 1ns/100ps
module mcu_model
  import bridge_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Requested levels
  input wire ctl_in_t req_a,
  input wire ctl_in_t req_b,
  input wire logic req_strap,
  // Control pins
  output logic chan_a_gate_in = 1'b0,
  output logic chan_a_dir_in1 = 1'b0,
  output logic chan_a_dir_in2 = 1'b0,
  output logic chan_b_gate_in = 1'b0,
  output logic chan_b_dir_in1 = 1'b0,
  output logic chan_b_dir_in2 = 1'b0,
  output logic bridge_pairing_strap = 1'b0
);
  // Pins change just after an edge and hold as levels between requests
  always @(posedge aclk) begin
    {chan_a_gate_in, chan_a_dir_in1, chan_a_dir_in2} <= req_a;
    {chan_b_gate_in, chan_b_dir_in1, chan_b_dir_in2} <= req_b;
    bridge_pairing_strap <= req_strap;
  end
endmodule
